// File: lsiu_top.v
// latched status interrupt unit: four status registers, masks, summary, info, avalon slave
// Operation
// - each status register owns a mask register, one mask bit per status bit
// - only status register bits can drive the interrupt output
// - reset clears every writable register to zero, masking all interrupts
// - a status bit interrupts only when its mask bit is one
// - a status bit latches to one on its event and holds until read
// - an event bit clears when read and sets only on a new event
// - a condition bit without its double select stays one after read while its alarm persists
// - writing one to a status bit refreshes it with latest info and clears it
// - writing zero to a status bit leaves its readable value unchanged
// - some conditions have a set-on-entry bit and a separate clear event bit
// - double bits interrupt both when the condition begins and when it ends
// - information register latches like status but never interrupts
// - sync info register is read-only, unlatched, real time, needs no select write
// - summary bits 0..3 flag status registers one..four, bits 4..7 read zero
`timescale 1ns/1ps
`include "lsiu_defs.vh"
module lsiu_top #(
  parameter W = 8,
  parameter [W-1:0] SR1_COND = 8'h0F,
  parameter [W-1:0] SR2_COND = 8'h0F,
  parameter [W-1:0] SR3_COND = 8'h0F,
  parameter [W-1:0] SR4_COND = 8'h0F,
  parameter [W-1:0] INFO_COND = 8'h0F
) (
  input wire clk,
  input wire srst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  input wire [W-1:0] status_reg_one_src,
  input wire [W-1:0] status_reg_two_src,
  input wire [W-1:0] status_reg_three_src,
  input wire [W-1:0] status_reg_four_src,
  input wire [W-1:0] info_src,
  input wire [W-1:0] e1_sync_realtime_info_src,
  input wire loss_of_frame,
  output reg [3:0] interrupt_source_summary
);
  reg [W-1:0] mask_ff [0:3];
  reg [W-1:0] dbl_ff [0:3];
  reg ack_ff;
  reg lof_dly_ff;
  wire [W-1:0] src_s [0:4];
  wire [W-1:0] sync_rt;
  wire lof_s;
  wire [W-1:0] rd_view [0:4];
  wire [W-1:0] lat [0:4];
  wire [W-1:0] sr2_src;
  wire acc;
  wire wr_lane0;
  reg [3:0] nxt_summary;
  reg [31:0] nxt_rdata;
  integer i;

  // request seen while still waiting; a write commits only at its completion edge
  assign acc = (avs_read | avs_write) & avs_waitrequest;
  assign wr_lane0 = avs_write & avs_byteenable[0] & ~avs_waitrequest;

  // all external sources are asynchronous; two flops before use
  lsiu_sync2 #(.W(6 * W + 1)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({status_reg_one_src, status_reg_two_src, status_reg_three_src,
        status_reg_four_src, info_src, e1_sync_realtime_info_src, loss_of_frame}),
    .q({src_s[0], src_s[1], src_s[2], src_s[3], src_s[4], sync_rt, lof_s})
  );

  // status two: bit0 condition on entering frame loss, bit4 event on regaining sync
  assign sr2_src = {src_s[1][7:5], ~lof_s & lof_dly_ff, src_s[1][3:1], lof_s};

  function sel_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      sel_hit = (addr == off);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sr
      wire [W-1:0] lvl;
      wire [W-1:0] cm;
      wire [7:0] off;
      wire [W-1:0] dm;
      localparam [7:0] IDX = g;
      assign lvl = (g == 1) ? sr2_src : src_s[g];
      assign cm = (g == 0) ? SR1_COND : (g == 1) ? SR2_COND : (g == 2) ? SR3_COND :
                  (g == 3) ? SR4_COND : INFO_COND;
      assign off = (g == 4) ? `LSIU_OFF_INFO : (`LSIU_OFF_SR1 + IDX);
      // info register has no double-edge select, so no index past the last one
      if (g == 4) begin : g_nodbl
        assign dm = {W{1'b0}};
      end else begin : g_dbl
        assign dm = dbl_ff[g];
      end
      // info register latches the same way but has no mask path
      lsiu_status_reg #(.W(W)) u_sr (
        .clk(clk),
        .srst(srst),
        .evt_level(lvl),
        .cond_mask(cm),
        .dbl_mask(dm),
        .sel_wr(wr_lane0 & sel_hit(avs_address, off)),
        .sel_data(avs_writedata[W-1:0]),
        .read_ff(rd_view[g]),
        .latch_bits(lat[g])
      );
    end
  endgenerate

  // masks and double-edge selects; summary read never touches status state
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < 4; i = i + 1) begin
        mask_ff[i] <= `LSIU_RST_BYTE;
        dbl_ff[i] <= `LSIU_RST_BYTE;
      end
      lof_dly_ff <= 1'b0;
    end else begin
      lof_dly_ff <= lof_s;
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_lane0 && sel_hit(avs_address, `LSIU_OFF_INTERRUPT_MASK_ONE + i[7:0])) begin
          mask_ff[i] <= avs_writedata[W-1:0];
        end
        if (wr_lane0 && sel_hit(avs_address, `LSIU_OFF_DBLSEL1 + i[7:0])) begin
          dbl_ff[i] <= avs_writedata[W-1:0];
        end
      end
    end
  end

  // summary flags from latched status and masks only; info never contributes
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      nxt_summary[i] = |(lat[i] & mask_ff[i]);
    end
  end

  // read mux; status reads show the selected view, sync info is live
  always @* begin
    nxt_rdata = `LSIU_UNMAPPED_DATA;
    case (avs_address)
      `LSIU_OFF_SUMMARY: nxt_rdata = {28'h000_0000, interrupt_source_summary};
      `LSIU_OFF_SR1: nxt_rdata = {24'h00_0000, rd_view[0]};
      `LSIU_OFF_SR2: nxt_rdata = {24'h00_0000, rd_view[1]};
      `LSIU_OFF_SR3: nxt_rdata = {24'h00_0000, rd_view[2]};
      `LSIU_OFF_SR4: nxt_rdata = {24'h00_0000, rd_view[3]};
      `LSIU_OFF_INTERRUPT_MASK_ONE: nxt_rdata = {24'h00_0000, mask_ff[0]};
      `LSIU_OFF_IMR2: nxt_rdata = {24'h00_0000, mask_ff[1]};
      `LSIU_OFF_IMR3: nxt_rdata = {24'h00_0000, mask_ff[2]};
      `LSIU_OFF_IMR4: nxt_rdata = {24'h00_0000, mask_ff[3]};
      `LSIU_OFF_INFO: nxt_rdata = {24'h00_0000, rd_view[4]};
      `LSIU_OFF_SYNC: nxt_rdata = {24'h00_0000, sync_rt};
      `LSIU_OFF_DBLSEL1: nxt_rdata = {24'h00_0000, dbl_ff[0]};
      `LSIU_OFF_DBLSEL2: nxt_rdata = {24'h00_0000, dbl_ff[1]};
      `LSIU_OFF_DBLSEL3: nxt_rdata = {24'h00_0000, dbl_ff[2]};
      `LSIU_OFF_DBLSEL4: nxt_rdata = {24'h00_0000, dbl_ff[3]};
      default: nxt_rdata = `LSIU_UNMAPPED_DATA;
    endcase
  end

  // one wait cycle per access so the status view written last cycle is visible
  always @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      irq <= 1'b0;
      interrupt_source_summary <= 4'h0;
    end else begin
      interrupt_source_summary <= nxt_summary;
      irq <= |nxt_summary;
      ack_ff <= acc & ~ack_ff;
      avs_waitrequest <= ~(acc & ~ack_ff);
      if (acc & ~ack_ff & avs_read) begin
        avs_readdata <= nxt_rdata;
      end
    end
  end
endmodule // lsiu_top

// File: lsiu_defs.vh
// register map, reset value and unmapped read value of the latched status interrupt unit
`ifndef LSIU_DEFS_VH
`define LSIU_DEFS_VH
`define LSIU_OFF_SUMMARY 8'h13
`define LSIU_OFF_SR1 8'h20
`define LSIU_OFF_SR2 8'h21
`define LSIU_OFF_SR3 8'h22
`define LSIU_OFF_SR4 8'h23
`define LSIU_OFF_INTERRUPT_MASK_ONE 8'h24
`define LSIU_OFF_IMR2 8'h25
`define LSIU_OFF_IMR3 8'h26
`define LSIU_OFF_IMR4 8'h27
`define LSIU_OFF_INFO 8'h28
`define LSIU_OFF_SYNC 8'h29
`define LSIU_OFF_DBLSEL1 8'h2A
`define LSIU_OFF_DBLSEL2 8'h2B
`define LSIU_OFF_DBLSEL3 8'h2C
`define LSIU_OFF_DBLSEL4 8'h2D
`define LSIU_RST_BYTE 8'h00
`define LSIU_UNMAPPED_DATA 32'h0000_0000
`endif

// File: lsiu_sync2.v
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
module lsiu_sync2 #(
  parameter W = 8
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (srst) begin
      meta_ff <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // lsiu_sync2

// File: lsiu_status_reg.v
// one latched status register with write-select read-and-clear and edge capture
`timescale 1ns/1ps
module lsiu_status_reg #(
  parameter W = 8
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] evt_level,
  input wire [W-1:0] cond_mask,
  input wire [W-1:0] dbl_mask,
  input wire sel_wr,
  input wire [W-1:0] sel_data,
  output reg [W-1:0] read_ff,
  output wire [W-1:0] latch_bits
);
  reg [W-1:0] prev_ff;
  reg [W-1:0] latch_ff;
  reg [W-1:0] nxt_latch;
  wire [W-1:0] rise;
  wire [W-1:0] fall;
  wire [W-1:0] hit;

  assign rise = evt_level & ~prev_ff;
  assign fall = ~evt_level & prev_ff;
  // events latch on rising edge, double bits also on the falling edge
  assign hit = rise | (fall & cond_mask & dbl_mask);
  assign latch_bits = latch_ff;

  // clear only selected bits; a new hit wins over the clear; a condition without double select stays while present
  always @* begin
    nxt_latch = latch_ff;
    if (sel_wr) begin
      nxt_latch = latch_ff & ~sel_data;
    end
    nxt_latch = nxt_latch | hit | (evt_level & cond_mask & ~dbl_mask);
  end

  always @(posedge clk) begin
    if (srst) begin
      prev_ff <= {W{1'b0}};
      latch_ff <= {W{1'b0}};
      read_ff <= {W{1'b0}};
    end else begin
      prev_ff <= evt_level;
      latch_ff <= nxt_latch;
      // selected bits copy the latest latch, others hold their old view
      if (sel_wr) begin
        read_ff <= (read_ff & ~sel_data) | (latch_ff & sel_data);
      end
    end
  end
endmodule // lsiu_status_reg

// File: lsiu_chk.sv
// checker: bus timing, reset state and interrupt summary of the status unit
`timescale 1ns/1ps
module lsiu_chk (
  input wire clk,
  input wire srst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq,
  input wire [3:0] interrupt_source_summary
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // request and completion qualifiers
  wire req = avs_read || avs_write;
  wire rd_done = avs_read && !avs_waitrequest;
  wire unmapped = (avs_address > 8'h2D) || (avs_address < 8'h20 && avs_address != 8'h13);
  // a request is taken, answered one cycle later, then waitrequest rises again
  sequence s_take; req && avs_waitrequest; endsequence
  sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_take |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_idle; !req |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  // reset is checked while it is asserted, so it must not disable itself
  property p_rst;
    disable iff (1'b0) srst |=> avs_waitrequest && !irq && interrupt_source_summary == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_quiet; $fell(srst) |-> !irq [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt before any mask write");
  property p_irq; irq == (|interrupt_source_summary); endproperty
  a_irq: assert property (p_irq) else $error("irq differs from summary");
  property p_sum; rd_done && avs_address == 8'h13 |-> avs_readdata[7:4] == 4'h0; endproperty
  a_sum: assert property (p_sum) else $error("summary unused bits set");
  property p_hi; rd_done |-> avs_readdata[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read lanes not zero");
  property p_unmapped; rd_done && unmapped |-> avs_readdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // lsiu_chk
bind lsiu_top lsiu_chk u_chk (.clk(clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq),
  .interrupt_source_summary(interrupt_source_summary));

// File: lsiu_host.sv
// host model: avalon master that services the status unit
`timescale 1ns/1ps
module lsiu_host (
  input wire clk,
  input wire [31:0] rdata,
  input wire wait_req,
  output logic [7:0] addr = 8'h00,
  output logic rd_en = 1'b0,
  output logic wr_en = 1'b0,
  output logic [31:0] wdata = 32'h0000_0000,
  output logic [3:0] be = 4'h1
);
  // request held until waitrequest is sampled low; data taken at that edge
  task automatic xfer(input bit w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= {24'h00_0000, d};
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
endmodule // lsiu_host

// File: tb_latched_status_interrupt_unit.sv
// self-checking bench of the latched status interrupt unit
`timescale 1ns/1ps
`include "lsiu_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_latched_status_interrupt_unit;
  logic clk = 1'b0, srst = 1'b1, lof = 1'b0, rq, wq, wt, irq;
  logic [7:0] src [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] inf = 8'h00, syn = 8'h00, ad, r, w, v;
  logic [31:0] wd, rdat;
  logic [3:0] be, sum;
  int n_fail = 0, checked = 0, seed = 32'h4f9b9e4e;
  int msk [4];
  lsiu_top DUT (.clk(clk), .srst(srst), .avs_address(ad), .avs_read(rq), .avs_write(wq),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
    .irq(irq), .status_reg_one_src(src[0]), .status_reg_two_src(src[1]),
    .status_reg_three_src(src[2]), .status_reg_four_src(src[3]), .info_src(inf),
    .e1_sync_realtime_info_src(syn), .loss_of_frame(lof), .interrupt_source_summary(sum));
  lsiu_host host (.clk(clk), .rdata(rdat), .wait_req(wt), .addr(ad), .rd_en(rq),
    .wr_en(wq), .wdata(wd), .be(be));
  initial forever #10 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, w);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, r);
  endtask
  // select byte then an immediate read of the same register
  task automatic sr(input logic [7:0] a, input logic [7:0] s);
    wr(a, s);
    rd(a);
  endtask
  // covers two sync flops, the latch and the summary stage
  task automatic nap;
    repeat (6) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(20 * 5000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // masks start cleared, then take random bytes
    for (int i = 0; i < 4; i++) begin
      rd(8'(`LSIU_OFF_INTERRUPT_MASK_ONE + i)); `CHK("mask", 8'h00, r)
      msk[i] = $random(seed) & 255;
      wr(8'(`LSIU_OFF_INTERRUPT_MASK_ONE + i), 8'(msk[i]));
      rd(8'(`LSIU_OFF_INTERRUPT_MASK_ONE + i)); `CHK("mask", 8'(msk[i]), r)
      wr(8'(`LSIU_OFF_INTERRUPT_MASK_ONE + i), 8'h80);
    end
    rd(8'h40); `CHK("unmapped", 8'h00, r)
    // one event per status register flags only its own summary bit
    for (int i = 0; i < 4; i++) begin
      src[i] <= 8'h80;
      nap();
      src[i] <= 8'h00;
      nap();
      `CHK("irq", 1'b1, irq)
      rd(`LSIU_OFF_SUMMARY); `CHK("summary", 8'(1 << i), r)
      rd(`LSIU_OFF_SUMMARY); `CHK("summary again", 8'(1 << i), r)
      sr(8'(`LSIU_OFF_SR1 + i), 8'h80); `CHK("status", 8'h80, r)
      nap(); `CHK("irq cleared", 1'b0, irq)
    end
    // masked event, held view, then a clear selecting bits 7 and 6
    src[0] <= 8'h40;
    nap(); `CHK("masked", 1'b0, irq)
    sr(`LSIU_OFF_SR1, 8'h00); `CHK("held view", 8'h80, r)
    sr(`LSIU_OFF_SR1, 8'hC0); `CHK("status", 8'h40, r)
    // condition persists across reads; handler masks then restores
    wr(`LSIU_OFF_INTERRUPT_MASK_ONE, 8'h01);
    src[0] <= 8'h41;
    nap();
    sr(`LSIU_OFF_SR1, 8'h01);
    sr(`LSIU_OFF_SR1, 8'h01); `CHK("condition", 8'h41, r)
    wr(`LSIU_OFF_INTERRUPT_MASK_ONE, 8'h00);
    nap(); `CHK("irq masked", 1'b0, irq)
    wr(`LSIU_OFF_INTERRUPT_MASK_ONE, 8'h01);
    src[0] <= 8'h00;
    nap();
    sr(`LSIU_OFF_SR1, 8'h01);
    sr(`LSIU_OFF_SR1, 8'h01); `CHK("condition gone", 8'h40, r)
    // double interrupt bit also interrupts when the condition ends
    wr(`LSIU_OFF_DBLSEL1, 8'h02);
    wr(`LSIU_OFF_INTERRUPT_MASK_ONE, 8'h02);
    src[0] <= 8'h02;
    nap();
    sr(`LSIU_OFF_SR1, 8'h02);
    sr(`LSIU_OFF_SR1, 8'h02);
    src[0] <= 8'h00;
    nap(); `CHK("irq on clear", 1'b1, irq)
    sr(`LSIU_OFF_SR1, 8'h02);
    sr(`LSIU_OFF_SR1, 8'h02);
    // frame loss: entry bit and a separate recovery event bit
    wr(`LSIU_OFF_IMR2, 8'h11);
    lof <= 1'b1;
    nap(); `CHK("summary sr2", 4'h2, sum)
    sr(`LSIU_OFF_SR2, 8'h11); `CHK("frame loss", 8'h81, r)
    lof <= 1'b0;
    nap();
    sr(`LSIU_OFF_SR2, 8'h11); `CHK("frame back", 8'h91, r)
    sr(`LSIU_OFF_SR2, 8'h11); `CHK("frame clear", 8'h80, r)
    // info latches without interrupting; sync view is live and read-only
    v = 8'($random(seed));
    inf <= v;
    syn <= ~v;
    nap(); `CHK("info irq", 1'b0, irq)
    sr(`LSIU_OFF_INFO, 8'hFF); `CHK("info", v, r)
    rd(`LSIU_OFF_SYNC); `CHK("sync", ~v, r)
    wr(`LSIU_OFF_SYNC, v);
    rd(`LSIU_OFF_SYNC); `CHK("sync ro", ~v, r)
    tally_and_finish();
  end
endmodule // tb_latched_status_interrupt_unit
